//--- core/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // Each bit passes two flops; the first is read only by the second.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        meta[i] <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        meta[i] <= async_in[i];
        sync_out[i] <= meta[i];
      end
    end
  end

endmodule

`default_nettype wire

//--- core/sync_serial_status_data_regs.sv
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

`include "sync_serial_map.svh"

//////////////////////////////////////////////////////////////////////////////

// What this block does
// - Status register resets to 9C; level, overrun, marker and start bits are zero.
// - Status bit 7 always reads one and ignores writes.
// - Status bits 4 to 2 ignore writes and read as ones.
// - Writing the level bit while no transfer is shifting drives the output pin; reading returns the pin level.
// - After a transfer the output pin keeps the last shifted bit.
// - Start of a transfer drops the level override and the marker enable.
// - With external clock, a clock pulse after completion sets the overrun flag.
// - Overrun clears only by writing zero after reading it as one.
// - Marker flag reads one only while the end marker is sent; read only.
// - Writing one to start begins a transfer in 8-bit or 16-bit mode only; writing zero does nothing.
// - Start flag stays one while waiting and shifting; clears at completion.
// - In 8-bit mode the lower register shifts out LSB first, input enters MSB.
// - In 16-bit mode upper register holds upper byte, lower holds lower byte.
// - In 16-bit mode upper shifts LSB first into lower; input enters upper MSB.
// - Apart from the input path, 16-bit mode behaves like 8-bit mode.
// - Data registers have no defined reset value.
// - Length mode 00 is 8-bit, 01 is 16-bit, 10 continuous clock, 11 reserved.
// - End-marker enable adds an end marker after the next data transfer only.
module sync_serial_status_data_regs #(
  parameter int HALF_CYCLES = `SSR_HALF_CYCLES,
  parameter int MARK_CYCLES = `SSR_MARK_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic end_marker_sending_flag,
  output logic xfer_done
);

  //////////////////////////////////////////////////////////////////////////////

  logic [1:0] pins_sync;
  logic sck_sync;
  logic sin_sync;

  // Link clock and data input come from another domain. The clock passes
  // inverted so that the synchroniser's reset value equals the idle high
  // line; otherwise a false rising edge after reset could set the overrun.
  pin_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in({~sck_in, serial_in_pin}),
    .sync_out(pins_sync)
  );

  assign sck_sync = ~pins_sync[1];
  assign sin_sync = pins_sync[0];

  //////////////////////////////////////////////////////////////////////////////

  sync_serial_pkg::xfer_state_t state;
  sync_serial_pkg::xfer_state_t next_state;
  sync_serial_pkg::ctrl_t ctrl;
  sync_serial_pkg::ctrl_t next_ctrl;
  logic [7:0] data_upper;
  logic [7:0] next_data_upper;
  logic [7:0] data_lower;
  logic [7:0] next_data_lower;
  logic serial_out;
  logic next_serial_out;
  logic overrun_flag;
  logic next_overrun_flag;
  logic overrun_seen;
  logic next_overrun_seen;
  logic marker_latched;
  logic next_marker_latched;
  logic [4:0] bit_count;
  logic [4:0] next_bit_count;
  logic [15:0] div_count;
  logic [15:0] next_div_count;
  logic [15:0] mark_count;
  logic [15:0] next_mark_count;
  logic sck_int;
  logic next_sck_int;
  logic sck_prev;
  logic done_pulse;
  logic next_done_pulse;
  logic [7:0] next_rdata;

  logic ext_rise;
  logic ext_fall;
  logic div_tick;
  logic int_rise;
  logic int_fall;
  logic shift_rise;
  logic shift_fall;
  logic busy;
  logic mode_16;
  logic mode_cont;
  logic [4:0] xfer_len;
  logic [7:0] status_value;
  logic [7:0] control_value;
  logic status_wr;

  assign busy = (state == sync_serial_pkg::ST_SHIFT);
  assign mode_16 = (ctrl.length_mode == sync_serial_pkg::LEN_16BIT);
  assign mode_cont = (ctrl.length_mode == sync_serial_pkg::LEN_CONT_CLOCK);
  assign xfer_len = mode_16 ? `SSR_LEN_16 : `SSR_LEN_8;

  // Edges of the link clock are found on the synchronised copy only.
  assign ext_rise = sck_sync & ~sck_prev;
  assign ext_fall = ~sck_sync & sck_prev;
  assign div_tick = (div_count == 16'(HALF_CYCLES - 1));
  assign int_rise = div_tick & ~sck_int;
  assign int_fall = div_tick & sck_int;
  assign shift_rise = busy & (ctrl.ext_clk ? ext_rise : int_rise);
  assign shift_fall = busy & (ctrl.ext_clk ? ext_fall : int_fall);

  always_comb begin
    status_value = 8'h00;
    status_value[`SSR_STAT_FIXED_BIT] = 1'b1;
    status_value[`SSR_STAT_LEVEL_BIT] = serial_out;
    status_value[`SSR_STAT_OVERRUN_BIT] = overrun_flag;
    status_value[4:2] = `SSR_RESERVED_READ;
    status_value[`SSR_STAT_MARKER_BIT] = end_marker_sending_flag;
    status_value[`SSR_STAT_START_BIT] = busy;
  end

  always_comb begin
    control_value = 8'h00;
    control_value[`SSR_CTRL_MODE_HI_BIT:`SSR_CTRL_MODE_LO_BIT] = ctrl.length_mode;
    control_value[`SSR_CTRL_MARKER_EN_BIT] = ctrl.end_marker_enable;
    control_value[`SSR_CTRL_EXT_CLK_BIT] = ctrl.ext_clk;
  end

  assign status_wr = wr & (addr == `SSR_OFS_STATUS) & ~busy;

  //////////////////////////////////////////////////////////////////////////////
  // Read port: data appear in the cycle after the strobe.

  always_comb begin
    next_rdata = 8'h00;
    if (rd) begin
      case (addr)
        `SSR_OFS_STATUS: next_rdata = status_value;
        `SSR_OFS_UPPER: next_rdata = data_upper;
        `SSR_OFS_LOWER: next_rdata = data_lower;
        `SSR_OFS_CONTROL: next_rdata = control_value;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control, status and sequencing.

  always_comb begin
    next_state = state;
    next_ctrl = ctrl;
    next_serial_out = serial_out;
    next_overrun_flag = overrun_flag;
    next_overrun_seen = overrun_seen;
    next_marker_latched = marker_latched;
    next_bit_count = bit_count;
    next_div_count = div_tick ? 16'h0000 : div_count + 16'h0001;
    next_mark_count = mark_count;
    next_sck_int = div_tick ? ~sck_int : sck_int;
    next_done_pulse = 1'b0;

    // The internal clock idles high and runs only while shifting, or always
    // in continuous clock mode.
    if (!busy && !mode_cont) begin
      next_sck_int = 1'b1;
      next_div_count = 16'h0000;
    end

    if (wr && addr == `SSR_OFS_CONTROL && !busy) begin
      next_ctrl.length_mode = sync_serial_pkg::length_mode_t'(
        wdata[`SSR_CTRL_MODE_HI_BIT:`SSR_CTRL_MODE_LO_BIT]);
      next_ctrl.end_marker_enable = wdata[`SSR_CTRL_MARKER_EN_BIT];
      next_ctrl.ext_clk = wdata[`SSR_CTRL_EXT_CLK_BIT];
    end

    if (rd && addr == `SSR_OFS_STATUS && overrun_flag) begin
      next_overrun_seen = 1'b1;
    end

    if (status_wr) begin
      next_serial_out = wdata[`SSR_STAT_LEVEL_BIT];
      if (!wdata[`SSR_STAT_OVERRUN_BIT] && overrun_seen) begin
        next_overrun_flag = 1'b0;
        next_overrun_seen = 1'b0;
      end
    end

    case (state)
      sync_serial_pkg::ST_IDLE: begin
        if (status_wr && wdata[`SSR_STAT_START_BIT] && !ctrl.length_mode[1]) begin
          next_state = sync_serial_pkg::ST_SHIFT;
          next_bit_count = 5'h00;
          next_serial_out = data_lower[0];
          next_marker_latched = ctrl.end_marker_enable;
          next_ctrl.end_marker_enable = 1'b0;
        end
      end
      sync_serial_pkg::ST_SHIFT: begin
        if (shift_fall && bit_count != 5'h00) begin
          next_serial_out = data_lower[0];
        end
        if (shift_rise) begin
          next_bit_count = bit_count + 5'h01;
          if (bit_count + 5'h01 == xfer_len) begin
            next_done_pulse = 1'b1;
            next_mark_count = 16'h0000;
            next_state = marker_latched ? sync_serial_pkg::ST_MARK : sync_serial_pkg::ST_IDLE;
          end
        end
      end
      sync_serial_pkg::ST_MARK: begin
        next_mark_count = mark_count + 16'h0001;
        if (mark_count == 16'(MARK_CYCLES - 1)) begin
          next_state = sync_serial_pkg::ST_IDLE;
          next_marker_latched = 1'b0;
        end
      end
      default: begin
        next_state = sync_serial_pkg::ST_IDLE;
      end
    endcase

    // late external clock
    // Placed last so a pulse in the clearing cycle still sets the flag.
    if (ctrl.ext_clk && !busy && ext_rise) begin
      next_overrun_flag = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= sync_serial_pkg::ST_IDLE;
      ctrl <= sync_serial_pkg::ctrl_t'(4'h0);
      serial_out <= 1'b0;
      overrun_flag <= 1'b0;
      overrun_seen <= 1'b0;
      marker_latched <= 1'b0;
      bit_count <= 5'h00;
      div_count <= 16'h0000;
      mark_count <= 16'h0000;
      sck_int <= 1'b1;
      sck_prev <= 1'b1;
      done_pulse <= 1'b0;
      rdata <= 8'h00;
    end else begin
      state <= next_state;
      ctrl <= next_ctrl;
      serial_out <= next_serial_out;
      overrun_flag <= next_overrun_flag;
      overrun_seen <= next_overrun_seen;
      marker_latched <= next_marker_latched;
      bit_count <= next_bit_count;
      div_count <= next_div_count;
      mark_count <= next_mark_count;
      sck_int <= next_sck_int;
      sck_prev <= sck_sync;
      done_pulse <= next_done_pulse;
      rdata <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Data shift registers. They carry no reset, which saves area; software
  // must load them before the first transfer.

  always_comb begin
    next_data_upper = data_upper;
    next_data_lower = data_lower;
    if (wr && !busy && addr == `SSR_OFS_UPPER) begin
      next_data_upper = wdata;
    end
    if (wr && !busy && addr == `SSR_OFS_LOWER) begin
      next_data_lower = wdata;
    end
    if (shift_rise) begin
      if (mode_16) begin
        next_data_upper = {sin_sync, data_upper[7:1]};
        next_data_lower = {data_upper[0], data_lower[7:1]};
      end else begin
        next_data_lower = {sin_sync, data_lower[7:1]};
      end
    end
  end

  always_ff @(posedge clk) begin
    data_upper <= next_data_upper;
    data_lower <= next_data_lower;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pins.

  assign serial_out_pin = serial_out;
  assign sck_out = sck_int;
  assign sck_oe = ~ctrl.ext_clk;
  assign end_marker_sending_flag = (state == sync_serial_pkg::ST_MARK);
  assign xfer_done = done_pulse;

endmodule

`default_nettype wire

//--- inc/sync_serial_map.svh
`ifndef SYNC_SERIAL_MAP_SVH
`define SYNC_SERIAL_MAP_SVH

// Register offsets on the plain register port.
`define SSR_OFS_STATUS 2'h0
`define SSR_OFS_UPPER 2'h1
`define SSR_OFS_LOWER 2'h2
`define SSR_OFS_CONTROL 2'h3

// Status register bit positions.
`define SSR_STAT_FIXED_BIT 7
`define SSR_STAT_LEVEL_BIT 6
`define SSR_STAT_OVERRUN_BIT 5
`define SSR_STAT_MARKER_BIT 1
`define SSR_STAT_START_BIT 0

// Control register field positions.
`define SSR_CTRL_MODE_HI_BIT 7
`define SSR_CTRL_MODE_LO_BIT 6
`define SSR_CTRL_MARKER_EN_BIT 5
`define SSR_CTRL_EXT_CLK_BIT 3

// Reset values.
`define SSR_STATUS_RESET 8'h9C
`define SSR_CONTROL_RESET 8'h00
`define SSR_RESERVED_READ 3'h7

// Transfer lengths in bits.
`define SSR_LEN_8 5'h08
`define SSR_LEN_16 5'h10

// Timing: internal shift clock half period and end-marker duration, in ns.
`define SSR_CLK_PERIOD_NS 100
`define SSR_HALF_PERIOD_NS 400
`define SSR_MARK_TIME_NS 2000
`define SSR_HALF_CYCLES (`SSR_HALF_PERIOD_NS / `SSR_CLK_PERIOD_NS)
`define SSR_MARK_CYCLES (`SSR_MARK_TIME_NS / `SSR_CLK_PERIOD_NS)

`endif

//--- inc/sync_serial_pkg.sv
`default_nettype none

package sync_serial_pkg;

  typedef enum logic [1:0] {
    LEN_8BIT,
    LEN_16BIT,
    LEN_CONT_CLOCK,
    LEN_RESERVED
  } length_mode_t;

  typedef struct packed {
    length_mode_t length_mode;
    logic end_marker_enable;
    logic ext_clk;
  } ctrl_t;

  typedef enum {
    ST_IDLE,
    ST_SHIFT,
    ST_MARK
  } xfer_state_t;

endpackage

`default_nettype wire

//--- verif/peer_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module peer_link_model (
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic serial_out_pin,
  input wire logic [15:0] tx_word,
  input wire logic arm,
  output logic sck_in,
  output logic serial_in_pin,
  output logic [15:0] rx_word,
  output int rises
);
  int idx;
  wire logic link = sck_oe ? sck_out : sck_in;
  initial begin
    sck_in = 1'b1;
    serial_in_pin = 1'b0;
    rx_word = 16'h0000;
    idx = 0;
    rises = 0;
  end
  always @(posedge arm) begin
    idx = 0;
    rises = 0;
    serial_in_pin = ~serial_in_pin;
  end
  // Outside a word the line toggles, so a stale bit is never sampled as data.
  always @(negedge link) begin
    serial_in_pin = (idx < 16) ? tx_word[idx] : ~serial_in_pin;
    idx = idx + 1;
  end
  always @(posedge link) begin
    rx_word = {serial_out_pin, rx_word[15:1]};
    rises = rises + 1;
  end
  // The clock stands high between frames and falls first.
  task automatic pulse(input int n);
    repeat (n) begin
      #400 sck_in = 1'b0;
      #400 sck_in = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

//--- verif/sync_serial_status_data_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sync_serial_status_data_regs_sva #(
  parameter int MARK_CYCLES = 20
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic serial_out_pin,
  input wire logic end_marker_sending_flag,
  input wire logic xfer_done
);
  int mark_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mark_cnt <= 0;
    end else begin
      mark_cnt <= end_marker_sending_flag ? mark_cnt + 1 : 0;
    end
  end
  AST_FIXED_ONE:
    assert property (rd && addr == 2'h0 |=> rdata[7]) else $error("status bit 7 read zero");
  AST_RSV_ONES:
    assert property (rd && addr == 2'h0 |=> rdata[4:2] == 3'h7) else $error("reserved bits wrong");
  AST_LEVEL_READ:
    assert property (rd && addr == 2'h0 |=> rdata[6] == $past(serial_out_pin)) else $error("level read wrong");
  AST_LEVEL_WRITE:
    assert property (wr && addr == 2'h0 && !wdata[0] |=> serial_out_pin == $past(wdata[6]))
      else $error("level write not on pin");
  AST_MARK_READ:
    assert property (rd && addr == 2'h0 |=> rdata[1] == $past(end_marker_sending_flag))
      else $error("marker bit wrong");
  AST_DONE_ONE:
    assert property (xfer_done |=> !xfer_done) else $error("done pulse too long");
  // Data may only move while the clock is low, so the peer samples a steady bit.
  AST_PIN_STEADY:
    assert property (sck_oe && sck_out && $past(sck_out) && !$past(wr) |-> $stable(serial_out_pin))
      else $error("pin moved while clock high");
  AST_MARK_AFTER_DONE:
    assert property ($rose(end_marker_sending_flag) |-> ##[0:2] xfer_done) else $error("marker without done");
  AST_MARK_LEN:
    assert property ($fell(end_marker_sending_flag) |-> mark_cnt >= MARK_CYCLES - 1 && mark_cnt <= MARK_CYCLES + 1)
      else $error("marker length wrong");
  cover property (xfer_done);
  cover property ($rose(end_marker_sending_flag));
  cover property (rd && addr == 2'h0);
endmodule
bind sync_serial_status_data_regs sync_serial_status_data_regs_sva #(.MARK_CYCLES(MARK_CYCLES)) sva_inst (
  .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .sck_out(sck_out), .sck_oe(sck_oe), .serial_out_pin(serial_out_pin),
  .end_marker_sending_flag(end_marker_sending_flag), .xfer_done(xfer_done));
`default_nettype wire

//--- verif/sync_serial_status_data_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sync_serial_status_data_regs_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic arm = 1'b0;
  logic [15:0] tx_word = 16'h0000;
  logic [7:0] rdata, d;
  logic [15:0] rx_word;
  logic sck_in, sck_out, sck_oe, serial_in_pin, serial_out_pin, end_marker_sending_flag, xfer_done;
  int rises, errors = 0, tests_run = 0, dones = 0, marks = 0, r0 = 0;
  always #50 clk = ~clk;
  sync_serial_status_data_regs #(.HALF_CYCLES(4), .MARK_CYCLES(4)) sync_serial_status_data_regs_inst (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .end_marker_sending_flag(end_marker_sending_flag), .xfer_done(xfer_done));
  peer_link_model peer_link_model_inst (.sck_out(sck_out), .sck_oe(sck_oe), .serial_out_pin(serial_out_pin),
    .tx_word(tx_word), .arm(arm), .sck_in(sck_in), .serial_in_pin(serial_in_pin), .rx_word(rx_word), .rises(rises));
  always @(posedge clk) begin
    if (xfer_done === 1'b1) dones++;
    if (end_marker_sending_flag === 1'b1) marks++;
  end
  task automatic conclude();
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic chk(input logic [1:0] a, input logic [7:0] exp, input string name);
    rd_reg(a);
    cmp(name, {8'h00, exp}, {8'h00, d});
  endtask
  task automatic xfer(input logic [7:0] c, input logic [7:0] up, input logic [7:0] lo, input logic [15:0] tx,
                      input int n);
    int k;
    tx_word <= tx;
    wr_reg(2'h3, c);
    wr_reg(2'h1, up);
    wr_reg(2'h2, lo);
    wr_reg(2'h0, 8'h40);
    arm <= 1'b1;
    wr_reg(2'h0, 8'h01);
    arm <= 1'b0;
    chk(2'h0, {1'b1, lo[0], 6'h1D}, "status at start");
    cmp("clock drive", {15'h0000, ~c[3]}, {15'h0000, sck_oe});
    if (c[3]) peer_link_model_inst.pulse(n);
    k = 0;
    do begin
      rd_reg(2'h0);
      k++;
    end while (d[0] !== 1'b0 && k < 100);
    cmp("busy wait", 16'h0000, {15'h0000, d[0]});
    cmp("shift clocks", 16'(n), rises[15:0]);
  endtask
  initial begin
    #2000000;
    errors++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    chk(2'h0, 8'h9C, "status reset");
    chk(2'h3, 8'h00, "control reset");
    wr_reg(2'h0, 8'h7E);
    chk(2'h0, 8'hDC, "status masked");
    wr_reg(2'h0, 8'h00);
    chk(2'h0, 8'h9C, "level low");
    for (int i = 0; i < 2; i++) begin
      wr_reg(2'h3, (i == 0) ? 8'h80 : 8'hC0);
      wr_reg(2'h0, 8'h01);
      r0 = rises;
      repeat (10) @(posedge clk);
      chk(2'h0, 8'h9C, "start refused");
      cmp("free clock", 16'(i == 0), 16'(rises != r0));
    end
    xfer(8'h00, 8'h00, 8'hA5, 16'h003C, 8);
    cmp("peer got byte", 16'h00A5, {8'h00, rx_word[15:8]});
    chk(2'h2, 8'h3C, "lower in");
    chk(2'h0, 8'hDC, "pin keeps last");
    cmp("no marker", 16'h0000, 16'(marks));
    xfer(8'h60, 8'h12, 8'h34, 16'hBEEF, 16);
    cmp("peer got word", 16'h1234, rx_word);
    chk(2'h1, 8'hBE, "upper in");
    chk(2'h2, 8'hEF, "lower in");
    repeat (10) @(posedge clk);
    chk(2'h0, 8'h9C, "after marker");
    chk(2'h3, 8'h40, "marker dropped");
    cmp("marker seen", 16'h0001, {15'h0000, marks > 0});
    xfer(8'h08, 8'h00, 8'h5A, 16'h0081, 8);
    cmp("ext peer byte", 16'h005A, {8'h00, rx_word[15:8]});
    chk(2'h2, 8'h81, "ext lower in");
    peer_link_model_inst.pulse(1);
    repeat (5) @(posedge clk);
    wr_reg(2'h0, 8'h00);
    chk(2'h0, 8'hBC, "overrun set");
    wr_reg(2'h0, 8'h20);
    chk(2'h0, 8'hBC, "overrun kept");
    wr_reg(2'h0, 8'h00);
    chk(2'h0, 8'h9C, "overrun cleared");
    cmp("done pulses", 16'h0003, 16'(dones));
    conclude();
  end
endmodule
`default_nettype wire
